// File: inc/tcc_defs.svh
// Register map, field positions and constants of the capture/compare channel
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
`define TCC_ADDR_W 4
`define TCC_OFS_IC_CTRL 4'h0
`define TCC_OFS_IC_DATA 4'h4
`define TCC_OFS_OC_CTRL 4'h8
`define TCC_OFS_OC_PRI 4'hC
`define TCC_OFS_OC_SEC 4'h0
`define TCC_OFS_OC_SEC_HI 1'b1
`define TCC_IC_SIDL 13
`define TCC_IC_TMR 7
`define TCC_IC_CPI_HI 6
`define TCC_IC_CPI_LO 5
`define TCC_IC_OV 4
`define TCC_IC_BNE 3
`define TCC_OC_SIDL 13
`define TCC_OC_FLT 4
`define TCC_OC_TSEL 3
`define TCC_MODE_HI 2
`define TCC_IC_DEPTH 4
`define TCC_IC_PTR_W 2
`define TCC_IC_CNT_W 3
`define TCC_ZERO16 16'h0000
`define TCC_PRE4 4'h3
`define TCC_PRE16 4'hF
`endif

// File: inc/tcc_pkg.sv
// Types of the capture/compare channel
`default_nettype none
package tcc_pkg;
	typedef enum logic [2:0] {
		TCC_IC_OFF = 3'h0,
		TCC_IC_BOTH = 3'h1,
		TCC_IC_FALL = 3'h2,
		TCC_IC_RISE = 3'h3,
		TCC_IC_RISE4 = 3'h4,
		TCC_IC_RISE16 = 3'h5,
		TCC_IC_UNUSED = 3'h6,
		TCC_IC_WAKE = 3'h7
	} tcc_ic_mode_type;
	typedef enum logic [2:0] {
		TCC_OC_OFF = 3'h0,
		TCC_OC_HIGH1 = 3'h1,
		TCC_OC_LOW1 = 3'h2,
		TCC_OC_TOGGLE = 3'h3,
		TCC_OC_DELAY1 = 3'h4,
		TCC_OC_CONT = 3'h5,
		TCC_OC_PWM = 3'h6,
		TCC_OC_PWMF = 3'h7
	} tcc_oc_mode_type;
endpackage
`default_nettype wire

// File: hw/tcc_capture_fifo.sv
// Four-word capture buffer with overflow detection
`timescale 1ns/1ns
`default_nettype none
`include "tcc_defs.svh"
module tcc_capture_fifo (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic clear_i,
	input wire logic push_i,
	input wire logic [15:0] data_i,
	input wire logic pop_i,
	// Status
	output logic [15:0] data_o,
	output logic nonempty_o,
	output logic overflow_o
);
	logic [15:0] mem_q [`TCC_IC_DEPTH];
	logic [`TCC_IC_PTR_W-1:0] wr_q;
	logic [`TCC_IC_PTR_W-1:0] rd_q;
	logic [`TCC_IC_CNT_W-1:0] cnt_q;
	logic full;
	logic do_push;
	logic do_pop;
	assign full = (cnt_q == `TCC_IC_CNT_W'(`TCC_IC_DEPTH));
	assign do_pop = pop_i && (cnt_q != '0);
	assign do_push = push_i && (!full || do_pop);
	assign nonempty_o = (cnt_q != '0); // [R5]
	assign data_o = mem_q[rd_q];
	always_ff @(posedge clk_i) begin
		if (do_push) begin
			mem_q[wr_q] <= data_i; // [R11]
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || clear_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (do_push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (do_pop) begin
				rd_q <= rd_q + 1'b1;
			end
			if (do_push && !do_pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (do_pop && !do_push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
	// Hardware-only flag; drops once software drains the buffer
	always_ff @(posedge clk_i) begin
		if (rst_i || clear_i) begin
			overflow_o <= 1'b0;
		end else if (push_i && full && !do_pop) begin
			overflow_o <= 1'b1; // [R12]
		end else if (cnt_q == '0) begin
			overflow_o <= 1'b0; // [R4]
		end
	end
endmodule
`default_nettype wire

// File: hw/tcc_channel.sv
// Capture/compare channel: edge capture half, compare/PWM half, Wishbone slave
//
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
`include "tcc_defs.svh"
// Function
// R1: Capture idle-halt bit set stops capture half while CPU idles.
// R2: Capture timer select one latches timer two, zero timer three.
// R3: Captures-per-interrupt 00..11 interrupts after one to four captures.
// R4: Overflow flag read-only, cleared by hardware only.
// R5: Buffer-nonempty flag reads one while a captured value waits.
// R6: Capture mode 111 is rising-edge wake source in sleep/idle only.
// R7: Modes 001 both edges, 010 falling, 011 rising capture.
// R8: Mode 100 every fourth rising edge, 101 every sixteenth via prescaler.
// R9: Mode 000 and 110 leave capture disabled.
// R10: Both-edges mode interrupts on every capture regardless of field.
// R11: Each capture stores selected sixteen-bit count in four-word buffer.
// R12: Capture into full buffer sets overflow and drops the value.
// R13: Compare count against one or two values, change pin on match.
// R14: Compare timer select one picks timer three, zero timer two.
// R15: Single pulse or pulse train, interrupts on match per mode.
// R16: Modes 000,001,010,100,101 set initial pin and interrupt edge.
// R17: Toggle mode keeps level at entry, inverts per match, both edges.
// R18: Mode 100 one delayed pulse, 101 continuous pulses between matches.
// R19: PWM 110 starts low if primary zero else high, no interrupt.
// R20: PWM 111 as 110 plus fault input, interrupt on fault fall.
// R21: Fault status bit set by hardware in mode 111, read-only.
// R22: Software stops the timer before writing compare control registers.
// R23: Only compare channels one and two drive a DMA request.
// R24: Stopped timer holds compare output and suppresses match events.
module tcc_channel #(
	parameter bit DMA_CAPABLE = 1'b1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`TCC_ADDR_W:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Shared timebase
	input wire logic [15:0] timer_two_count_i,
	input wire logic [15:0] timer_three_count_i,
	input wire logic timer_two_run_i,
	input wire logic timer_three_run_i,
	// Power state
	input wire logic cpu_idle_i,
	input wire logic cpu_sleep_i,
	// Pins
	input wire logic capture_input_pin_i,
	input wire logic compare_fault_input_i,
	output logic compare_output_pin_o,
	output logic compare_pin_owned_o,
	// Events
	output logic capture_irq_o,
	output logic capture_wake_o,
	output logic compare_irq_o,
	output logic compare_dma_o
);
	// ----------------------------------------
	// Registers and bus
	// ----------------------------------------
	logic ic_sidl_q;
	logic ic_tmr_q;
	logic [1:0] ic_cpi_q;
	tcc_pkg::tcc_ic_mode_type ic_mode_q;
	logic oc_sidl_q;
	logic oc_tsel_q;
	logic oc_flt_q;
	tcc_pkg::tcc_oc_mode_type oc_mode_q;
	logic [15:0] oc_pri_q;
	logic [15:0] oc_sec_q;
	logic [15:0] fifo_data;
	logic fifo_ne;
	logic fifo_ov;
	logic req;
	logic wr;
	logic lo_en;
	logic ic_ctrl_hit;
	logic ic_data_hit;
	logic oc_ctrl_hit;
	logic oc_pri_hit;
	logic oc_sec_hit;
	logic [15:0] ic_ctrl_rd;
	logic [15:0] oc_ctrl_rd;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = req && wb_we_i;
	assign lo_en = wb_sel_i[0] && wb_sel_i[1];
	assign ic_ctrl_hit = !wb_adr_i[`TCC_ADDR_W] &&
		(wb_adr_i[`TCC_ADDR_W-1:0] == `TCC_OFS_IC_CTRL);
	assign ic_data_hit = !wb_adr_i[`TCC_ADDR_W] &&
		(wb_adr_i[`TCC_ADDR_W-1:0] == `TCC_OFS_IC_DATA);
	assign oc_ctrl_hit = !wb_adr_i[`TCC_ADDR_W] &&
		(wb_adr_i[`TCC_ADDR_W-1:0] == `TCC_OFS_OC_CTRL);
	assign oc_pri_hit = !wb_adr_i[`TCC_ADDR_W] &&
		(wb_adr_i[`TCC_ADDR_W-1:0] == `TCC_OFS_OC_PRI);
	assign oc_sec_hit = (wb_adr_i[`TCC_ADDR_W] == `TCC_OFS_OC_SEC_HI) &&
		(wb_adr_i[`TCC_ADDR_W-1:0] == `TCC_OFS_OC_SEC);
	assign ic_ctrl_rd = {2'h0, ic_sidl_q, 5'h00, ic_tmr_q, ic_cpi_q,
		fifo_ov, fifo_ne, ic_mode_q}; // [R4] [R5]
	assign oc_ctrl_rd = {2'h0, oc_sidl_q, 8'h00, oc_flt_q, oc_tsel_q,
		oc_mode_q}; // [R21]
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= '0;
			if (req && !wb_we_i) begin
				if (ic_ctrl_hit) begin
					wb_dat_o <= {16'h0000, ic_ctrl_rd};
				end else if (ic_data_hit) begin
					wb_dat_o <= {16'h0000, fifo_data};
				end else if (oc_ctrl_hit) begin
					wb_dat_o <= {16'h0000, oc_ctrl_rd};
				end else if (oc_pri_hit) begin
					wb_dat_o <= {16'h0000, oc_pri_q};
				end else if (oc_sec_hit) begin
					wb_dat_o <= {16'h0000, oc_sec_q};
				end
			end
		end
	end
	// Status bits are not writable; only control fields take the write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ic_sidl_q <= 1'b0;
			ic_tmr_q <= 1'b0;
			ic_cpi_q <= 2'h0;
			ic_mode_q <= tcc_pkg::TCC_IC_OFF;
		end else if (wr && ic_ctrl_hit && lo_en) begin
			ic_sidl_q <= wb_dat_i[`TCC_IC_SIDL];
			ic_tmr_q <= wb_dat_i[`TCC_IC_TMR];
			ic_cpi_q <= wb_dat_i[`TCC_IC_CPI_HI:`TCC_IC_CPI_LO];
			ic_mode_q <= tcc_pkg::tcc_ic_mode_type'(wb_dat_i[`TCC_MODE_HI:0]);
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			oc_sidl_q <= 1'b0;
			oc_tsel_q <= 1'b0;
			oc_mode_q <= tcc_pkg::TCC_OC_OFF;
		end else if (wr && oc_ctrl_hit && lo_en) begin
			oc_sidl_q <= wb_dat_i[`TCC_OC_SIDL];
			oc_tsel_q <= wb_dat_i[`TCC_OC_TSEL];
			oc_mode_q <= tcc_pkg::tcc_oc_mode_type'(wb_dat_i[`TCC_MODE_HI:0]);
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			oc_pri_q <= `TCC_ZERO16;
			oc_sec_q <= `TCC_ZERO16;
		end else if (wr && lo_en) begin
			if (oc_pri_hit) begin
				oc_pri_q <= wb_dat_i[15:0];
			end
			if (oc_sec_hit) begin
				oc_sec_q <= wb_dat_i[15:0];
			end
		end
	end
	// ----------------------------------------
	// Capture half
	// ----------------------------------------
	logic pin_q;
	logic rise;
	logic fall;
	logic ic_run;
	logic ic_on;
	logic [3:0] pre_q;
	logic cap_evt;
	logic [1:0] cap_cnt_q;
	logic [15:0] cap_val;
	logic ic_mode_chg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= capture_input_pin_i;
		end
	end
	assign rise = capture_input_pin_i && !pin_q;
	assign fall = !capture_input_pin_i && pin_q;
	assign ic_on = (ic_mode_q != tcc_pkg::TCC_IC_OFF) &&
		(ic_mode_q != tcc_pkg::TCC_IC_UNUSED) &&
		(ic_mode_q != tcc_pkg::TCC_IC_WAKE); // [R9]
	assign ic_run = ic_on && !(ic_sidl_q && cpu_idle_i); // [R1]
	assign ic_mode_chg = wr && ic_ctrl_hit && lo_en;
	// Prescaler counts rising edges; restarts on any mode write
	always_ff @(posedge clk_i) begin
		if (rst_i || ic_mode_chg) begin
			pre_q <= 4'h0;
		end else if (ic_run && rise) begin
			pre_q <= pre_q + 4'h1;
		end
	end
	always_comb begin
		cap_evt = 1'b0;
		if (ic_run) begin
			unique case (ic_mode_q)
				tcc_pkg::TCC_IC_BOTH: cap_evt = rise || fall; // [R7]
				tcc_pkg::TCC_IC_FALL: cap_evt = fall; // [R7]
				tcc_pkg::TCC_IC_RISE: cap_evt = rise; // [R7]
				tcc_pkg::TCC_IC_RISE4: begin
					cap_evt = rise && (pre_q[1:0] == `TCC_PRE4); // [R8]
				end
				tcc_pkg::TCC_IC_RISE16: begin
					cap_evt = rise && (pre_q == `TCC_PRE16); // [R8]
				end
				default: cap_evt = 1'b0;
			endcase
		end
	end
	assign cap_val = ic_tmr_q ? timer_two_count_i : timer_three_count_i; // [R2]
	tcc_capture_fifo u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(!ic_on),
		.push_i(cap_evt),
		.data_i(cap_val),
		.pop_i(req && !wb_we_i && ic_data_hit),
		.data_o(fifo_data),
		.nonempty_o(fifo_ne),
		.overflow_o(fifo_ov)
	);
	always_ff @(posedge clk_i) begin
		if (rst_i || ic_mode_chg) begin
			cap_cnt_q <= 2'h0;
			capture_irq_o <= 1'b0;
		end else begin
			capture_irq_o <= 1'b0;
			if (cap_evt) begin
				if (ic_mode_q == tcc_pkg::TCC_IC_BOTH) begin
					capture_irq_o <= 1'b1; // [R10]
				end else if (cap_cnt_q == ic_cpi_q) begin
					cap_cnt_q <= 2'h0;
					capture_irq_o <= 1'b1; // [R3]
				end else begin
					cap_cnt_q <= cap_cnt_q + 2'h1;
				end
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			capture_wake_o <= 1'b0;
		end else begin
			capture_wake_o <= (ic_mode_q == tcc_pkg::TCC_IC_WAKE) &&
				(cpu_sleep_i || cpu_idle_i) && rise; // [R6]
		end
	end
	// ----------------------------------------
	// Compare half
	// ----------------------------------------
	logic [15:0] oc_cnt;
	logic oc_tmr_run;
	logic oc_live;
	logic m_pri;
	logic m_sec;
	logic done_q;
	logic flt_q;
	logic init;
	logic pin_d;
	logic oc_irq_d;
	logic pwm_mode;
	assign oc_cnt = oc_tsel_q ? timer_three_count_i : timer_two_count_i; // [R14]
	assign oc_tmr_run = oc_tsel_q ? timer_three_run_i : timer_two_run_i;
	assign oc_live = oc_tmr_run && !(oc_sidl_q && cpu_idle_i); // [R24]
	assign m_pri = oc_live && (oc_cnt == oc_pri_q); // [R13]
	assign m_sec = oc_live && (oc_cnt == oc_sec_q);
	assign init = wr && oc_ctrl_hit && lo_en;
	assign pwm_mode = (oc_mode_q == tcc_pkg::TCC_OC_PWM) ||
		(oc_mode_q == tcc_pkg::TCC_OC_PWMF);
	// Mode write reinitialises the pin from the newly written mode
	always_comb begin
		pin_d = compare_output_pin_o;
		unique case (oc_mode_q)
			tcc_pkg::TCC_OC_OFF: pin_d = 1'b0; // [R16]
			tcc_pkg::TCC_OC_HIGH1: if (m_pri && !done_q) pin_d = 1'b1;
			tcc_pkg::TCC_OC_LOW1: if (m_pri && !done_q) pin_d = 1'b0;
			tcc_pkg::TCC_OC_TOGGLE: if (m_pri) pin_d = !pin_d; // [R17]
			tcc_pkg::TCC_OC_DELAY1, tcc_pkg::TCC_OC_CONT: begin
				if (m_pri && !done_q) pin_d = 1'b1; // [R18]
				else if (m_sec && pin_d) pin_d = 1'b0;
			end
			tcc_pkg::TCC_OC_PWM, tcc_pkg::TCC_OC_PWMF: begin
				if (m_sec) pin_d = 1'b0;
				if (oc_live && oc_cnt == `TCC_ZERO16) begin
					pin_d = (oc_pri_q != `TCC_ZERO16);
				end
				if (flt_q) pin_d = 1'b0;
			end
		endcase
	end
	always_comb begin
		oc_irq_d = 1'b0;
		unique case (oc_mode_q)
			tcc_pkg::TCC_OC_HIGH1: oc_irq_d = pin_d && !compare_output_pin_o;
			tcc_pkg::TCC_OC_TOGGLE: oc_irq_d = pin_d != compare_output_pin_o;
			tcc_pkg::TCC_OC_LOW1, tcc_pkg::TCC_OC_DELAY1,
			tcc_pkg::TCC_OC_CONT: oc_irq_d = !pin_d && compare_output_pin_o;
			tcc_pkg::TCC_OC_PWMF: begin
				oc_irq_d = !compare_fault_input_i && !flt_q; // [R20]
			end
			default: oc_irq_d = 1'b0; // [R19]
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			compare_output_pin_o <= 1'b0;
		end else if (init) begin
			unique case (tcc_pkg::tcc_oc_mode_type'(wb_dat_i[`TCC_MODE_HI:0]))
				tcc_pkg::TCC_OC_LOW1: compare_output_pin_o <= 1'b1; // [R16]
				tcc_pkg::TCC_OC_TOGGLE: begin
					compare_output_pin_o <= compare_output_pin_o; // [R17]
				end
				tcc_pkg::TCC_OC_PWM, tcc_pkg::TCC_OC_PWMF: begin
					compare_output_pin_o <= (oc_pri_q != `TCC_ZERO16); // [R19]
				end
				default: compare_output_pin_o <= 1'b0; // [R16]
			endcase
		end else begin
			compare_output_pin_o <= pin_d; // [R15]
		end
	end
	// One-shot modes stop after their pulse; continuous mode never does
	always_ff @(posedge clk_i) begin
		if (rst_i || init) begin
			done_q <= 1'b0;
		end else if (((oc_mode_q == tcc_pkg::TCC_OC_HIGH1 ||
			oc_mode_q == tcc_pkg::TCC_OC_LOW1) && m_pri) ||
			(oc_mode_q == tcc_pkg::TCC_OC_DELAY1 && m_sec &&
			compare_output_pin_o)) begin
			done_q <= 1'b1; // [R18]
		end
	end
	// Fault is a low level on the fault input; sampled each cycle while in mode 111, not held
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flt_q <= 1'b0;
		end else begin
			flt_q <= (oc_mode_q == tcc_pkg::TCC_OC_PWMF) &&
				!compare_fault_input_i;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || init || oc_mode_q != tcc_pkg::TCC_OC_PWMF) begin
			oc_flt_q <= 1'b0; // [R21]
		end else if (flt_q) begin
			oc_flt_q <= 1'b1; // [R21]
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			compare_irq_o <= 1'b0;
			compare_dma_o <= 1'b0;
		end else begin
			compare_irq_o <= oc_irq_d && !init;
			compare_dma_o <= DMA_CAPABLE && oc_irq_d && !init; // [R23]
		end
	end
	assign compare_pin_owned_o = (oc_mode_q != tcc_pkg::TCC_OC_OFF) ||
		pwm_mode; // [R16]
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_overflow_sticky: assert property (@(posedge clk_i) // [R4]
		disable iff (rst_i) (fifo_ov && fifo_ne && ic_on) |=> fifo_ov)
		else $error("overflow flag dropped while data waits");
	a_both_edge_irq: assert property (@(posedge clk_i) // [R10]
		disable iff (rst_i) (cap_evt && ic_mode_q == tcc_pkg::TCC_IC_BOTH &&
		!ic_mode_chg) |=> capture_irq_o)
		else $error("both-edge capture without interrupt");
	a_capture_off: assert property (@(posedge clk_i) // [R9]
		disable iff (rst_i) !ic_on |=> !fifo_ne && !capture_irq_o)
		else $error("capture while disabled");
	a_idle_halt: assert property (@(posedge clk_i) // [R1]
		disable iff (rst_i) (ic_sidl_q && cpu_idle_i) |=> !capture_irq_o)
		else $error("capture during idle halt");
	a_pwm_no_irq: assert property (@(posedge clk_i) // [R19]
		disable iff (rst_i) (oc_mode_q == tcc_pkg::TCC_OC_PWM &&
		$past(oc_mode_q) == tcc_pkg::TCC_OC_PWM) |-> !compare_irq_o)
		else $error("interrupt in plain pwm mode");
	a_stopped_hold: assert property (@(posedge clk_i) // [R24]
		disable iff (rst_i) (!oc_tmr_run && !init && !flt_q &&
		oc_mode_q != tcc_pkg::TCC_OC_OFF) |=> $stable(compare_output_pin_o))
		else $error("pin moved with timer stopped");
	a_fault_flag: assert property (@(posedge clk_i) // [R21]
		disable iff (rst_i) oc_flt_q |-> oc_mode_q == tcc_pkg::TCC_OC_PWMF)
		else $error("fault flag outside fault pwm mode");
	a_dma_gate: assert property (@(posedge clk_i) // [R23]
		disable iff (rst_i) compare_dma_o |-> DMA_CAPABLE && compare_irq_o)
		else $error("dma request without capability");
	a_high_shot: assert property (@(posedge clk_i) // [R16]
		disable iff (rst_i) (oc_mode_q == tcc_pkg::TCC_OC_HIGH1 && m_pri &&
		!done_q && !init) |=> compare_output_pin_o && compare_irq_o)
		else $error("one-shot high did not fire");
endmodule
`default_nettype wire

// File: testbench/tcc_pin_model.sv
// Far-side pins: pulse source on the capture pin, fault source
`timescale 1ns/1ns
`default_nettype none
module tcc_pin_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Requests from the bench
	input wire logic toggle_i,
	input wire logic fault_i,
	// Pins
	output logic capture_input_pin_o,
	output logic compare_fault_input_o
);
	// Pin changes one edge after a request, like an external driver
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			capture_input_pin_o <= 1'b0;
		end else if (toggle_i) begin
			capture_input_pin_o <= ~capture_input_pin_o;
		end
	end
	// Fault line idles high; low means fault
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			compare_fault_input_o <= 1'b1;
		end else begin
			compare_fault_input_o <= ~fault_i;
		end
	end
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench of the capture/compare channel
`timescale 1ns/1ns
`default_nettype none
module tb;
	localparam logic [15:0] MCTL [0:6] = '{16'h0061, 16'h0042, 16'h0023,
		16'h0004, 16'h0005, 16'h0000, 16'h2003};
	localparam int MTOG [0:6] = '{4, 8, 8, 32, 32, 8, 8};
	localparam int MIRQ [0:6] = '{4, 1, 2, 4, 1, 0, 0};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [4:0] adr = 5'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [15:0] t2 = 16'hFFFF;
	logic [15:0] t3 = 16'hFFFF;
	logic run2 = 1'b0;
	logic run3 = 1'b0;
	logic idle = 1'b0;
	logic sleep = 1'b0;
	logic tgl = 1'b0;
	logic flt = 1'b0;
	logic cap_pin, flt_pin, oc_pin, owned, cirq, wake, oirq, dma;
	logic [15:0] expq [$];
	logic [15:0] v [0:4];
	logic [15:0] p, s, w;
	int n_errors = 0;
	int checks_done = 0;
	int n_cirq = 0;
	int n_wake = 0;
	int n_oirq = 0;
	int n_dma = 0;
	int cycles = 0;
	int b;

	always #5 clk_i = ~clk_i;

	tcc_channel #(.DMA_CAPABLE(1'b1)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .timer_two_count_i(t2),
		.timer_three_count_i(t3), .timer_two_run_i(run2),
		.timer_three_run_i(run3), .cpu_idle_i(idle), .cpu_sleep_i(sleep),
		.capture_input_pin_i(cap_pin), .compare_fault_input_i(flt_pin),
		.compare_output_pin_o(oc_pin), .compare_pin_owned_o(owned),
		.capture_irq_o(cirq), .capture_wake_o(wake),
		.compare_irq_o(oirq), .compare_dma_o(dma));
	tcc_pin_model u_pins (.clk_i(clk_i), .rst_i(rst_i), .toggle_i(tgl),
		.fault_i(flt), .capture_input_pin_o(cap_pin),
		.compare_fault_input_o(flt_pin));

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run();
		if (n_errors == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Read data is judged where the answer appears, in request order
	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 20000) begin
			n_errors++;
			complete_run();
		end
		if (cirq === 1'b1) n_cirq++;
		if (wake === 1'b1) n_wake++;
		if (oirq === 1'b1) n_oirq++;
		if (dma === 1'b1) n_dma++;
		if (wb_ack_o === 1'b1 && we === 1'b0) begin
			if (expq.size() == 0) begin
				check("unexpected ack", 32'h0000_0001, 32'h0000_0000);
			end else begin
				check("read data", wb_dat_o, {16'h0000, expq.pop_front()});
			end
		end
	end

	// Held until the edge that samples ack, released right after it
	task automatic wb(input logic [4:0] a, input logic is_wr,
		input logic [15:0] d, input logic [3:0] s_i);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= is_wr;
		adr <= a;
		wdat <= {16'h0000, d};
		sel <= s_i;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		wb(a, 1'b1, d, 4'hF);
	endtask

	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		expq.push_back(e);
		wb(a, 1'b0, 16'h0000, 4'hF);
	endtask

	// Spaced so the pin is stable for several samples per level
	task automatic tog(input int n);
		repeat (n) begin
			tgl <= 1'b1;
			@(posedge clk_i);
			tgl <= 1'b0;
			repeat (3) @(posedge clk_i);
		end
		repeat (4) @(posedge clk_i);
	endtask

	task automatic hit(input logic ts, input logic [15:0] val);
		if (ts) t3 <= val;
		else t2 <= val;
		@(posedge clk_i);
		t2 <= 16'hFFFF;
		t3 <= 16'hFFFF;
		repeat (4) @(posedge clk_i);
	endtask

	// Timers stopped around every control write
	task automatic oc(input logic [15:0] ctl);
		run2 <= 1'b0;
		run3 <= 1'b0;
		wr(5'h08, ctl);
		run2 <= 1'b1;
		run3 <= 1'b1;
	endtask

	task automatic pin(input logic e);
		@(negedge clk_i);
		check("compare pin", {31'h0, oc_pin}, {31'h0, e});
		// Back on the rising edge so later stimulus changes there
		@(posedge clk_i);
	endtask

	initial begin
		void'($urandom(17));
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(5'h00, 16'h0000);
		rd(5'h08, 16'h0000);
		rd(5'h0C, 16'h0000);
		rd(5'h10, 16'h0000);
		wr(5'h14, 16'hFFFF);
		rd(5'h14, 16'h0000);
		// ------------------------------------------------------------
		// Capture edge modes
		// ------------------------------------------------------------
		idle <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			b = n_cirq;
			wr(5'h00, MCTL[i]);
			tog(MTOG[i]);
			check("capture irqs", n_cirq - b, MIRQ[i]);
			wr(5'h00, 16'h0000);
		end
		idle <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			sleep <= (i == 0);
			b = n_wake;
			wr(5'h00, 16'h0007);
			tog(8);
			check("wake pulses", n_wake - b, (i == 0) ? 4 : 0);
		end
		sleep <= 1'b0;
		// ------------------------------------------------------------
		// Capture buffer, overflow, timer select
		// ------------------------------------------------------------
		wr(5'h00, 16'h0083);
		for (int i = 0; i < 5; i++) begin
			v[i] = 16'($urandom());
			t2 <= v[i];
			tog(2);
		end
		rd(5'h00, 16'h009B);
		for (int i = 0; i < 4; i++) rd(5'h04, v[i]);
		rd(5'h00, 16'h0083);
		w = 16'($urandom());
		wr(5'h00, 16'h001B);
		t3 <= w;
		tog(2);
		rd(5'h00, 16'h000B);
		rd(5'h04, w);
		t2 <= 16'hFFFF;
		t3 <= 16'hFFFF;
		// ------------------------------------------------------------
		// Compare modes
		// ------------------------------------------------------------
		p = 16'($urandom_range(16'h7FFF, 16'h0001));
		s = p + 16'h0100;
		wr(5'h0C, p);
		wr(5'h10, s);
		wb(5'h0C, 1'b1, 16'h1234, 4'h1);
		rd(5'h0C, p);
		b = n_oirq;
		oc(16'h0001);
		pin(1'b0);
		hit(1'b0, p);
		pin(1'b1);
		oc(16'h0002);
		pin(1'b1);
		hit(1'b0, p);
		pin(1'b0);
		oc(16'h0003);
		pin(1'b0);
		hit(1'b0, p);
		pin(1'b1);
		run2 <= 1'b0;
		hit(1'b0, p);
		pin(1'b1);
		run2 <= 1'b1;
		hit(1'b0, p);
		pin(1'b0);
		oc(16'h0009);
		hit(1'b0, p);
		pin(1'b0);
		hit(1'b1, p);
		pin(1'b1);
		check("compare irqs", n_oirq - b, 5);
		oc(16'h0004);
		hit(1'b0, p);
		pin(1'b1);
		hit(1'b0, s);
		pin(1'b0);
		hit(1'b0, p);
		pin(1'b0);
		oc(16'h0005);
		hit(1'b0, p);
		hit(1'b0, s);
		pin(1'b0);
		hit(1'b0, p);
		pin(1'b1);
		check("pulse irqs", n_oirq - b, 7);
		wr(5'h0C, 16'h0000);
		oc(16'h0006);
		pin(1'b0);
		wr(5'h0C, p);
		oc(16'h0006);
		pin(1'b1);
		check("pwm irqs", n_oirq - b, 7);
		oc(16'h0007);
		flt <= 1'b1;
		repeat (4) @(posedge clk_i);
		pin(1'b0);
		rd(5'h08, 16'h0017);
		check("pin owned", {31'h0, owned}, 32'h0000_0001);
		flt <= 1'b0;
		check("fault irqs", n_oirq - b, 8);
		check("dma requests", n_dma, 8);
		oc(16'h0000);
		@(negedge clk_i);
		check("pin owned", {31'h0, owned}, 32'h0000_0000);
		rd(5'h08, 16'h0000);
		repeat (4) @(posedge clk_i);
		complete_run();
	end
endmodule
`default_nettype wire
